// file: inc/xrfc_defs.vh
`ifndef XRFC_DEFS_VH
`define XRFC_DEFS_VH
`define XRFC_WIDTH_1LINE 2'h0
`define XRFC_WIDTH_8LINE 2'h2
`define XRFC_OPTION_DATA_ENABLE_NONE 4'h0
`define XRFC_OPTION_DATA_ENABLE_TOP1 4'h8
`define XRFC_OPTION_DATA_ENABLE_TOP2 4'hc
`define XRFC_OPTION_DATA_ENABLE_TOP3 4'he
`define XRFC_OPTION_DATA_ENABLE_ALL4 4'hf
`define XRFC_LVL_LOW 2'h0
`define XRFC_LVL_HIGH 2'h1
`define XRFC_LVL_PREV 2'h2
`define XRFC_LVL_HIZ 2'h3
`define XRFC_DUMMY_RESET 5'h00
`define XRFC_SCK_DIV 8'h14
`define XRFC_FIFO_DEPTH 4
`endif

// file: design/xrfc_fifo.v
`timescale 1ns/10ps
module xrfc_fifo #(
	parameter WIDTH = 32,
	parameter DEPTH = 4,
	parameter AW = 2
) (
	input wire clk,
	input wire rst,
	input wire in_valid,
	output wire in_ready,
	input wire [WIDTH-1:0] in_data,
	output wire out_valid,
	input wire out_ready,
	output wire [WIDTH-1:0] out_data
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wp;
	reg [AW-1:0] rp;
	reg [AW:0] cnt;
	wire push;
	wire pop;
	assign in_ready = (cnt != DEPTH[AW:0]);
	assign out_valid = (cnt != {(AW+1){1'b0}});
	assign out_data = mem[rp];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;
	always @(posedge clk) begin
		if (rst) begin
			wp <= {AW{1'b0}};
			rp <= {AW{1'b0}};
			cnt <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				mem[wp] <= in_data;
				wp <= (wp == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp + 1'b1;
			end
			if (pop)
				rp <= (rp == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp + 1'b1;
			if (push & ~pop)
				cnt <= cnt + 1'b1;
			else if (pop & ~push)
				cnt <= cnt - 1'b1;
		end
	end
endmodule

// file: design/xrfc_top.v
`timescale 1ns/10ps
`include "xrfc_defs.vh"
// Functional notes
// - Option data on one or eight lines
// - Enable field picks top N option bytes
// - Option data SDR or DDR
// - Up to four programmable option bytes sent
// - Dummy phase only when enabled
// - Dummy count one through thirty-two
// - Read data on one or eight lines
// - Read data sampled SDR or DDR
// - Idle levels per line 0..3
// - Previous choice keeps last bit and output enable
// - Lines 3,2 fixed in one-line transfer
// - Line 0 fixed in one-line read
// - Each mapped read becomes a flash frame
// - Width code 0 one line, 2 eight
// - Enable codes 8, c, e, f
// - Dummy code is count minus one
// - Levels low, high, previous, hi-z
module xrfc_top #(
	parameter SCK_DIV = `XRFC_SCK_DIV,
	parameter FIFO_DEPTH = `XRFC_FIFO_DEPTH
) (
	input wire CLK,
	input wire RST,
	input wire RD_REQ,
	output wire RD_READY,
	input wire [31:0] RD_ADDR,
	output wire RD_DATA_VALID,
	input wire RD_DATA_READY,
	output wire [31:0] RD_DATA,
	input wire [7:0] COMMAND,
	input wire COMMAND_ENABLE,
	input wire [7:0] OPTIONAL_COMMAND,
	input wire OPTIONAL_COMMAND_ENABLE,
	input wire ADDRESS_ENABLE,
	input wire [1:0] OPTION_DATA_WIDTH,
	input wire [3:0] OPTION_DATA_ENABLE,
	input wire OPTION_DATA_DOUBLE_RATE,
	input wire [7:0] OPTION_BYTE_TOP,
	input wire [7:0] OPTION_BYTE_2,
	input wire [7:0] OPTION_BYTE_1,
	input wire [7:0] OPTION_BYTE_BOTTOM,
	input wire DUMMY_PHASE_ENABLE,
	input wire [4:0] DUMMY_CYCLE_COUNT,
	input wire [1:0] READ_DATA_WIDTH,
	input wire READ_DATA_DOUBLE_RATE,
	input wire [1:0] IDLE_LEVEL_LINE3,
	input wire [1:0] IDLE_LEVEL_LINE2,
	input wire [1:0] IDLE_LEVEL_LINE1,
	input wire [1:0] IDLE_LEVEL_LINE0,
	input wire [1:0] SINGLE_LINE_LEVEL_LINE3,
	input wire [1:0] SINGLE_LINE_LEVEL_LINE2,
	input wire [1:0] SINGLE_LINE_READ_LEVEL_LINE0,
	output wire BUSY,
	output reg FLASH_CHIP_SELECT_N,
	output reg FLASH_SCK,
	input wire [7:0] FLASH_IO_IN,
	output reg [7:0] FLASH_IO_OUT,
	output reg [7:0] FLASH_IO_OE
);
	localparam ST_IDLE = 3'd0;
	localparam ST_CMD = 3'd1;
	localparam ST_OCMD = 3'd2;
	localparam ST_ADDR = 3'd3;
	localparam ST_OPT = 3'd4;
	localparam ST_DUMMY = 3'd5;
	localparam ST_DATA = 3'd6;
	localparam ST_DONE = 3'd7;

	// Apply one 2-bit level code to a line
	function [1:0] lvl_drive;
		input [1:0] code;
		input prev_bit;
		input prev_oe;
		begin
			case (code)
			`XRFC_LVL_LOW: lvl_drive = 2'b10;
			`XRFC_LVL_HIGH: lvl_drive = 2'b11;
			`XRFC_LVL_PREV: lvl_drive = {prev_oe, prev_bit};
			default: lvl_drive = 2'b00;
			endcase
		end
	endfunction

	reg [2:0] state;
	reg [7:0] div_cnt;
	reg sck_phase;
	reg [6:0] bit_cnt;
	reg [31:0] shreg;
	reg [31:0] rx;
	reg [7:0] io_in_s1;
	reg [7:0] io_in_s2;
	reg [7:0] last_out;
	reg [7:0] last_oe;
	reg fifo_push;
	reg [31:0] fifo_word;
	reg [1:0] cur_width;
	reg cur_ddr;
	reg [2:0] next_state;
	reg [6:0] phase_len;
	wire half_tick;
	wire fifo_in_ready;
	wire [1:0] d3;
	wire [1:0] d2;
	wire [1:0] d1;
	wire [1:0] d0;
	wire [1:0] f3;
	wire [1:0] f2;
	wire [1:0] f0;
	wire [2:0] opt_bytes;
	wire shift_edge;
	wire sample_edge;

	assign half_tick = (div_cnt == SCK_DIV[7:0] - 8'h01);
	assign BUSY = (state != ST_IDLE);
	// Accept a new read only when the result can be buffered
	assign RD_READY = (state == ST_IDLE) & fifo_in_ready;
	assign opt_bytes = {2'b00, OPTION_DATA_ENABLE[3]} +
		{2'b00, OPTION_DATA_ENABLE[2]} + {2'b00, OPTION_DATA_ENABLE[1]} +
		{2'b00, OPTION_DATA_ENABLE[0]};

	// Shift on falling edge, sample on rising; DDR uses both
	assign shift_edge = half_tick & (sck_phase | cur_ddr);
	assign sample_edge = half_tick & (~sck_phase | cur_ddr);

	// Skip disabled phases in fixed order
	always @* begin
		next_state = ST_DATA;
		if (state < ST_CMD && COMMAND_ENABLE)
			next_state = ST_CMD;
		else if (state < ST_OCMD && OPTIONAL_COMMAND_ENABLE)
			next_state = ST_OCMD;
		else if (state < ST_ADDR && ADDRESS_ENABLE)
			next_state = ST_ADDR;
		else if (state < ST_OPT && OPTION_DATA_ENABLE != `XRFC_OPTION_DATA_ENABLE_NONE)
			next_state = ST_OPT;
		else if (state < ST_DUMMY && DUMMY_PHASE_ENABLE)
			next_state = ST_DUMMY;
	end

	// Phase length in shift edges (sample edges for the read phase)
	always @* begin
		case (next_state)
		ST_CMD: phase_len = 7'd8;
		ST_OCMD: phase_len = 7'd8;
		ST_ADDR: phase_len = 7'd32;
		ST_OPT: begin
			if (OPTION_DATA_WIDTH == `XRFC_WIDTH_8LINE)
				phase_len = {4'h0, opt_bytes};
			else
				phase_len = {1'b0, opt_bytes, 3'b000};
		end
		ST_DUMMY: phase_len = {2'b00, DUMMY_CYCLE_COUNT} + 7'd1;
		ST_DATA: begin
			if (READ_DATA_WIDTH == `XRFC_WIDTH_8LINE)
				phase_len = 7'd4;
			else
				phase_len = 7'd32;
		end
		default: phase_len = 7'd0;
		endcase
	end

	always @(posedge CLK) begin
		if (RST) begin
			io_in_s1 <= 8'h00;
			io_in_s2 <= 8'h00;
		end else begin
			io_in_s1 <= FLASH_IO_IN;
			io_in_s2 <= io_in_s1;
		end
	end

	always @(posedge CLK) begin
		if (RST) begin
			state <= ST_IDLE;
			div_cnt <= 8'h00;
			sck_phase <= 1'b0;
			bit_cnt <= 7'd0;
			shreg <= 32'h0000_0000;
			rx <= 32'h0000_0000;
			cur_width <= `XRFC_WIDTH_1LINE;
			cur_ddr <= 1'b0;
			fifo_push <= 1'b0;
			fifo_word <= 32'h0000_0000;
			FLASH_CHIP_SELECT_N <= 1'b1;
			FLASH_SCK <= 1'b0;
		end else begin
			fifo_push <= 1'b0;
			div_cnt <= (state == ST_IDLE || half_tick) ? 8'h00 :
				div_cnt + 8'h01;
			case (state)
			ST_IDLE: begin
				sck_phase <= 1'b0;
				FLASH_SCK <= 1'b0;
				if (RD_REQ && fifo_in_ready) begin
					FLASH_CHIP_SELECT_N <= 1'b0;
					state <= next_state;
					bit_cnt <= phase_len;
					rx <= RD_ADDR;
					shreg <= {COMMAND, 24'h00_0000};
					cur_width <= `XRFC_WIDTH_1LINE;
					cur_ddr <= 1'b0;
					if (next_state == ST_OCMD)
						shreg <= {OPTIONAL_COMMAND, 24'h00_0000};
					else if (next_state == ST_ADDR)
						shreg <= RD_ADDR;
				end
			end
			ST_DONE: begin
				FLASH_SCK <= 1'b0;
				if (half_tick) begin
					FLASH_CHIP_SELECT_N <= 1'b1;
					state <= ST_IDLE;
				end
			end
			default: begin
				if (half_tick) begin
					sck_phase <= ~sck_phase;
					FLASH_SCK <= ~sck_phase;
				end
				if (sample_edge && state == ST_DATA) begin
					if (cur_width == `XRFC_WIDTH_8LINE)
						rx <= {rx[23:0], io_in_s2};
					else
						rx <= {rx[30:0], io_in_s2[1]};
				end
				if (shift_edge && state != ST_DATA) begin
					if (cur_width == `XRFC_WIDTH_8LINE)
						shreg <= {shreg[23:0], 8'h00};
					else
						shreg <= {shreg[30:0], 1'b0};
				end
				if ((state == ST_DATA ? sample_edge : shift_edge) &&
					bit_cnt != 7'd0)
					bit_cnt <= bit_cnt - 7'd1;
				if ((state == ST_DATA ? sample_edge : shift_edge) &&
					bit_cnt == 7'd1) begin
					if (state == ST_DATA) begin
						fifo_push <= 1'b1;
						fifo_word <= (cur_width == `XRFC_WIDTH_8LINE) ?
							{rx[23:0], io_in_s2} : {rx[30:0], io_in_s2[1]};
						state <= ST_DONE;
					end else begin
						state <= next_state;
						bit_cnt <= phase_len;
						if (next_state == ST_OCMD)
							shreg <= {OPTIONAL_COMMAND, 24'h00_0000};
						else if (next_state == ST_ADDR)
							shreg <= rx;
						else if (next_state == ST_OPT) begin
							// Top byte first, downward
							shreg <= {OPTION_BYTE_TOP, OPTION_BYTE_2,
								OPTION_BYTE_1, OPTION_BYTE_BOTTOM};
							cur_width <= OPTION_DATA_WIDTH;
							cur_ddr <= OPTION_DATA_DOUBLE_RATE;
						end else if (next_state == ST_DATA) begin
							cur_width <= READ_DATA_WIDTH;
							cur_ddr <= READ_DATA_DOUBLE_RATE;
						end else begin
							cur_width <= `XRFC_WIDTH_1LINE;
							cur_ddr <= 1'b0;
						end
					end
				end
			end
			endcase
		end
	end

	assign d3 = lvl_drive(IDLE_LEVEL_LINE3, last_out[3], last_oe[3]);
	assign d2 = lvl_drive(IDLE_LEVEL_LINE2, last_out[2], last_oe[2]);
	assign d1 = lvl_drive(IDLE_LEVEL_LINE1, last_out[1], last_oe[1]);
	assign d0 = lvl_drive(IDLE_LEVEL_LINE0, last_out[0], last_oe[0]);
	assign f3 = lvl_drive(SINGLE_LINE_LEVEL_LINE3, last_out[3], last_oe[3]);
	assign f2 = lvl_drive(SINGLE_LINE_LEVEL_LINE2, last_out[2], last_oe[2]);
	// Host keeps this hi-z unless reads are one line wide
	assign f0 = lvl_drive(SINGLE_LINE_READ_LEVEL_LINE0, last_out[0],
		last_oe[0]);

	// Registered pin drive; last state remembered for "previous"
	always @(posedge CLK) begin
		if (RST) begin
			FLASH_IO_OUT <= 8'h00;
			FLASH_IO_OE <= 8'h00;
			last_out <= 8'h00;
			last_oe <= 8'h00;
		end else if (state == ST_IDLE) begin
			FLASH_IO_OUT <= {4'h0, d3[0], d2[0], d1[0], d0[0]};
			FLASH_IO_OE <= {4'h0, d3[1], d2[1], d1[1], d0[1]};
		end else begin
			// Select is still low in ST_DONE: frame levels hold until it rises
			if (state == ST_DATA || state == ST_DUMMY || state == ST_DONE) begin
				if (cur_width == `XRFC_WIDTH_8LINE || (state == ST_DUMMY &&
					READ_DATA_WIDTH != `XRFC_WIDTH_1LINE)) begin
					FLASH_IO_OUT <= 8'h00;
					FLASH_IO_OE <= 8'h00;
				end else begin
					FLASH_IO_OUT <= {4'h0, f3[0], f2[0], 1'b0, f0[0]};
					FLASH_IO_OE <= {4'h0, f3[1], f2[1], 1'b0, f0[1]};
				end
			end else if (cur_width == `XRFC_WIDTH_8LINE) begin
				FLASH_IO_OUT <= shreg[31:24];
				FLASH_IO_OE <= 8'hff;
			end else begin
				FLASH_IO_OUT <= {4'h0, f3[0], f2[0], 1'b0, shreg[31]};
				FLASH_IO_OE <= {4'h0, f3[1], f2[1], 1'b0, 1'b1};
			end
			last_out <= FLASH_IO_OUT;
			last_oe <= FLASH_IO_OE;
		end
	end

	xrfc_fifo #(
		.WIDTH(32),
		.DEPTH(FIFO_DEPTH),
		.AW(2)
	) u_fifo (
		.clk(CLK),
		.rst(RST),
		.in_valid(fifo_push),
		.in_ready(fifo_in_ready),
		.in_data(fifo_word),
		.out_valid(RD_DATA_VALID),
		.out_ready(RD_DATA_READY),
		.out_data(RD_DATA)
	);
endmodule

// file: verification/xrfc_props.sv
`timescale 1ns/10ps
module xrfc_props (
	input wire CLK,
	input wire RST,
	input wire RD_REQ,
	input wire RD_READY,
	input wire RD_DATA_VALID,
	input wire RD_DATA_READY,
	input wire [31:0] RD_DATA,
	input wire BUSY,
	input wire FLASH_CHIP_SELECT_N,
	input wire [7:0] FLASH_IO_OUT,
	input wire [7:0] FLASH_IO_OE,
	input wire [1:0] OPTION_DATA_WIDTH,
	input wire [1:0] READ_DATA_WIDTH,
	input wire [1:0] IDLE_LEVEL_LINE3,
	input wire [1:0] IDLE_LEVEL_LINE2,
	input wire [1:0] IDLE_LEVEL_LINE0,
	input wire [1:0] SINGLE_LINE_LEVEL_LINE3,
	input wire [1:0] SINGLE_LINE_LEVEL_LINE2
);
	reg [1:0] idle_n;
	default clocking dc @(posedge CLK); endclocking
	default disable iff (RST);
	// Skip the first three cycles after select rises, the hand-off cycle among them
	always @(posedge CLK) begin
		if (RST || !FLASH_CHIP_SELECT_N)
			idle_n <= 2'h0;
		else if (idle_n != 2'h3)
			idle_n <= idle_n + 2'h1;
	end
	sequence take_s;
		RD_REQ && RD_READY;
	endsequence
	sequence open_s;
		!FLASH_CHIP_SELECT_N ##1 !FLASH_CHIP_SELECT_N;
	endsequence
	property idle_p(code, oe, out);
		idle_n == 2'h3 |-> code == 2'h2 || (code == 2'h3 && !oe)
			|| (code == 2'h0 && oe && !out) || (code == 2'h1 && oe && out);
	endproperty
	frame_open_a: assert property (take_s |=> open_s)
		else $error("no frame after take");
	busy_refuse_a: assert property (BUSY |-> !RD_READY)
		else $error("ready while busy");
	word_hold_a: assert property (RD_DATA_VALID && !RD_DATA_READY
		|=> RD_DATA_VALID && $stable(RD_DATA)) else $error("word lost");
	push_frame_a: assert property ($rose(RD_DATA_VALID)
		|-> !FLASH_CHIP_SELECT_N) else $error("word outside frame");
	idle_line3_a: assert property (idle_p(IDLE_LEVEL_LINE3,
		FLASH_IO_OE[3], FLASH_IO_OUT[3])) else $error("line3 idle");
	idle_line2_a: assert property (idle_p(IDLE_LEVEL_LINE2,
		FLASH_IO_OE[2], FLASH_IO_OUT[2])) else $error("line2 idle");
	idle_line0_a: assert property (idle_p(IDLE_LEVEL_LINE0,
		FLASH_IO_OE[0], FLASH_IO_OUT[0])) else $error("line0 idle");
	single_lines_a: assert property (!FLASH_CHIP_SELECT_N
		&& !$past(FLASH_CHIP_SELECT_N) && OPTION_DATA_WIDTH == 2'h0
		&& READ_DATA_WIDTH == 2'h0 && !SINGLE_LINE_LEVEL_LINE3[1]
		&& !SINGLE_LINE_LEVEL_LINE2[1] |-> FLASH_IO_OE[3:2] == 2'h3
		&& FLASH_IO_OUT[3:2] == {SINGLE_LINE_LEVEL_LINE3[0],
		SINGLE_LINE_LEVEL_LINE2[0]}) else $error("lines 3,2 level");
endmodule
bind xrfc_top xrfc_props props (.*);

// file: verification/xrfc_flash_model.sv
`timescale 1ns/10ps
module xrfc_flash_model (
	input wire clk,
	input wire cs_n,
	input wire sck,
	input wire wide,
	input wire [7:0] lead,
	input wire [31:0] word,
	output reg [7:0] io
);
	reg [7:0] falls = 8'h00;
	reg sck_d = 1'b0;
	int k;
	initial io = 8'h00;
	always @(posedge clk) begin
		sck_d <= sck;
		if (cs_n)
			falls <= 8'h00;
		else if (sck_d && !sck)
			falls <= falls + 8'h01;
	end
	// Bus not held outside the read window: toggle so stale bits show
	always @(negedge clk) begin
		k = falls - lead;
		if (cs_n || falls < lead || k > (wide ? 3 : 31))
			io <= ~io;
		else if (wide)
			io <= word[8 * (3 - k) +: 8];
		else
			io <= {6'h00, word[31 - k], 1'b0};
	end
endmodule

// file: verification/testbench.sv
`timescale 1ns/10ps
module testbench;
	reg CLK = 1'b0, RST = 1'b1, RD_REQ = 1'b0, RD_DATA_READY = 1'b0;
	reg [31:0] RD_ADDR = 32'h0000_0000;
	reg [7:0] COMMAND = 8'h0b, OPTIONAL_COMMAND = 8'hf4;
	reg COMMAND_ENABLE = 1'b1, OPTIONAL_COMMAND_ENABLE = 1'b0;
	reg ADDRESS_ENABLE = 1'b1, OPTION_DATA_DOUBLE_RATE = 1'b0;
	reg [1:0] OPTION_DATA_WIDTH = 2'h0, READ_DATA_WIDTH = 2'h0;
	reg [3:0] OPTION_DATA_ENABLE = 4'h0;
	reg [7:0] OPTION_BYTE_TOP = 8'ha5, OPTION_BYTE_2 = 8'h3c;
	reg [7:0] OPTION_BYTE_1 = 8'h96, OPTION_BYTE_BOTTOM = 8'h0f;
	reg DUMMY_PHASE_ENABLE = 1'b0, READ_DATA_DOUBLE_RATE = 1'b0;
	reg [4:0] DUMMY_CYCLE_COUNT = 5'h00;
	reg [1:0] IDLE_LEVEL_LINE3 = 2'h0, IDLE_LEVEL_LINE2 = 2'h1;
	reg [1:0] IDLE_LEVEL_LINE1 = 2'h2, IDLE_LEVEL_LINE0 = 2'h3;
	reg [1:0] SINGLE_LINE_LEVEL_LINE3 = 2'h1, SINGLE_LINE_LEVEL_LINE2 = 2'h0;
	reg [1:0] SINGLE_LINE_READ_LEVEL_LINE0 = 2'h1;
	wire RD_READY, RD_DATA_VALID, BUSY, FLASH_CHIP_SELECT_N, FLASH_SCK;
	wire [31:0] RD_DATA;
	wire [7:0] FLASH_IO_IN, FLASH_IO_OUT, FLASH_IO_OE;
	reg [7:0] lead = 8'h00, rises = 8'h00;
	reg [31:0] word = 32'h0000_0000;
	reg [63:0] cap = 64'h0000_0000_0000_0000;
	reg sck_q = 1'b0;
	int opt0 = 0, optn = 0, obits = 0, miscompares = 0, cmp_count = 0;
	xrfc_top dut (.*);
	xrfc_flash_model flash (.clk(CLK), .cs_n(FLASH_CHIP_SELECT_N),
		.sck(FLASH_SCK), .wide(READ_DATA_WIDTH == 2'h2), .lead(lead),
		.word(word), .io(FLASH_IO_IN));
	initial forever #2 CLK = ~CLK;
	// Option phase capture at each link rising edge
	always @(posedge CLK) begin
		sck_q <= FLASH_SCK;
		if (FLASH_CHIP_SELECT_N)
			rises <= 8'h00;
		else if (FLASH_SCK && !sck_q) begin
			rises <= rises + 8'h01;
			if (rises >= opt0 && rises < opt0 + optn)
				cap <= OPTION_DATA_WIDTH == 2'h2 ? {cap[55:0], FLASH_IO_OUT}
					: {cap[62:0], FLASH_IO_OUT[0]};
		end
	end
	task automatic check(input string what, input [63:0] exp, got);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic setup;
		obits = 8 * (OPTION_DATA_ENABLE == 4'hf ? 4 : OPTION_DATA_ENABLE
			== 4'he ? 3 : OPTION_DATA_ENABLE == 4'hc ? 2 : OPTION_DATA_ENABLE
			== 4'h8);
		opt0 = 8 * COMMAND_ENABLE + 8 * OPTIONAL_COMMAND_ENABLE + 32;
		optn = OPTION_DATA_WIDTH == 2'h2 ? obits / 8 : obits;
		lead = 8'(opt0 + optn + (DUMMY_PHASE_ENABLE ? DUMMY_CYCLE_COUNT + 1 : 0));
	endtask
	task automatic req(input [31:0] w);
		int t;
		RD_REQ = 1'b1;
		RD_ADDR = ~w;
		for (t = 0; !RD_READY && t < 30000; t++) @(negedge CLK);
		if (t == 30000) miscompares++;
		word = w;
		@(negedge CLK);
		RD_REQ = 1'b0;
		@(negedge CLK);
	endtask
	task automatic get(input [31:0] w);
		int t;
		for (t = 0; !RD_DATA_VALID && t < 30000; t++) @(negedge CLK);
		if (t == 30000) miscompares++;
		check("read word", w, RD_DATA);
		RD_DATA_READY = 1'b1;
		@(negedge CLK);
		RD_DATA_READY = 1'b0;
		@(negedge CLK);
	endtask
	task automatic frame(input [31:0] w);
		setup();
		req(w);
		get(w);
		check("option bytes", {OPTION_BYTE_TOP, OPTION_BYTE_2, OPTION_BYTE_1,
			OPTION_BYTE_BOTTOM} >> (32 - obits), cap & ((64'h1 << obits) - 1));
		repeat (25) @(negedge CLK);
		check("idle", 6'h1c, {FLASH_IO_OUT[3:2], FLASH_IO_OE[3:0]});
	endtask
	task automatic s_plain;
		setup();
		req(32'hc3a5_5a3c);
		check("busy ready", 1'b0, RD_READY);
		repeat (40 * (lead + 16)) @(negedge CLK);
		check("one-line levels", 6'h2f, {FLASH_IO_OUT[3:2],
			FLASH_IO_OUT[0], FLASH_IO_OE[3:2], FLASH_IO_OE[0]});
		get(32'hc3a5_5a3c);
	endtask
	task automatic s_opt;
		DUMMY_PHASE_ENABLE = 1'b1;
		DUMMY_CYCLE_COUNT = 5'h01;
		for (int i = 0; i < 5; i++) begin
			OPTION_DATA_ENABLE = 4'(20'h0_fec8 >> (4 * i));
			frame(32'h1234_5678 + i);
		end
	endtask
	task automatic s_dummy;
		COMMAND_ENABLE = 1'b0;
		OPTIONAL_COMMAND_ENABLE = 1'b1;
		DUMMY_CYCLE_COUNT = 5'h13;
		frame(32'h8001_7ffe);
		COMMAND_ENABLE = 1'b1;
		OPTIONAL_COMMAND_ENABLE = 1'b0;
	endtask
	task automatic s_octal;
		OPTION_DATA_WIDTH = 2'h2;
		READ_DATA_WIDTH = 2'h2;
		SINGLE_LINE_READ_LEVEL_LINE0 = 2'h3;
		OPTION_DATA_ENABLE = 4'hf;
		DUMMY_CYCLE_COUNT = 5'h04;
		frame(32'h6c93_a50f);
		OPTION_DATA_WIDTH = 2'h0;
		READ_DATA_WIDTH = 2'h0;
		SINGLE_LINE_READ_LEVEL_LINE0 = 2'h1;
		OPTION_DATA_ENABLE = 4'h0;
		DUMMY_PHASE_ENABLE = 1'b0;
	endtask
	task automatic s_fifo;
		int t;
		setup();
		for (int i = 0; i < 4; i++) req(32'h0f0f_0000 + i);
		for (t = 0; BUSY && t < 30000; t++) @(negedge CLK);
		if (t == 30000) miscompares++;
		check("full ready", 1'b0, RD_READY);
		for (int i = 0; i < 4; i++) get(32'h0f0f_0000 + i);
	endtask
	task automatic finish_test;
		$display("compares %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		repeat (10) @(negedge CLK);
		RST = 1'b0;
		repeat (4) @(negedge CLK);
		check("reset idle", 6'h1c, {FLASH_IO_OUT[3:2], FLASH_IO_OE[3:0]});
		s_plain();
		s_opt();
		s_dummy();
		s_octal();
		s_fifo();
		finish_test();
	end
	initial begin
		#400_000;
		miscompares++;
		finish_test();
	end
endmodule
